// file: rtl/scdt_cfg.svh
// constants of the system clock divider and trim block
// Notes on behaviour
// - divided system clock drives processor, flash, io and converter domains
// - divider changes are glitch free, no period shorter than old or new
// - new rate starts after the old period ends, then new periods follow
// - divider counts on the undivided clock; its count is not readable
// - clock output fuse drives system clock on pin, overriding port function
// - clock output pin stays still while held in reset
// - the clock output pin carries the divided system clock
// - every reset loads trim register with factory value; software may overwrite
// - trim top bit selects the lower or higher overlapping range
// - lower seven trim bits tune frequency monotonically within the range
// - change enable is set only by a write of exactly 0x80
// - change enable clears four cycles after set, or when a divider value with bit 7 clear is written
// - rewriting change enable inside its window neither extends nor clears it
// - divider register bits 6 to 4 read as zero
// - divider resets to 0000, or 0011 when divide by eight fuse programmed
// - any divider value is accepted whatever the divide by eight fuse
// - divider code n divides by 2 to the n, codes above 1000 reserved
`ifndef SCDT_CFG_SVH
`define SCDT_CFG_SVH
`define SCDT_OFS_TRIM 32'h0000_0000
`define SCDT_OFS_DIVCTL 32'h0000_0004
`define SCDT_CE_BIT 7
`define SCDT_SEL_MSB 3
`define SCDT_CE_WINDOW 3'h4
`define SCDT_SEL_MAX 4'h8
`define SCDT_SEL_RST 4'h0
`define SCDT_SEL_DIV8 4'h3
`define SCDT_CE_WRITE 8'h80
`endif

// file: rtl/scdt_pkg.sv
// types of the system clock divider and trim block
package scdt_pkg;
  typedef struct packed {
    logic proc;
    logic flash;
    logic io;
    logic conv;
  } scdt_clk_dom_t;

  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hsel;
    logic hready;
    logic [31:0] hwdata;
  } scdt_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } scdt_ahb_rsp_t;

  typedef struct packed {
    logic init;
    logic [7:0] trim;
    logic [3:0] sel;
    logic [3:0] act_sel;
    logic ce;
    logic [2:0] ce_cnt;
    logic [7:0] cnt;
    logic clk_lvl;
    logic tick;
    logic clkout;
    logic wr_pend;
    logic wr_div;
    logic [31:0] rdata;
  } scdt_state_t;
endpackage

// file: rtl/scdt_top.sv
// system clock divider with protected change sequence and oscillator trim
`timescale 1ns/1ps
`include "scdt_cfg.svh"
module scdt_top (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // fuses and factory trim
  input wire logic i_divide_by_eight_fuse,
  input wire logic i_clock_output_pin_fuse,
  input wire logic [7:0] i_trim_factory,
  // ahb-lite slave
  input wire scdt_pkg::scdt_ahb_req_t i_ahb,
  output scdt_pkg::scdt_ahb_rsp_t o_ahb,
  // divided clock domains
  output scdt_pkg::scdt_clk_dom_t o_clk_dom,
  output logic o_sys_tick,
  // oscillator trim
  output logic [7:0] o_oscillator_trim,
  output logic o_trim_range_select,
  output logic [6:0] o_trim_fine,
  // clock output pin
  output logic o_clkout_o,
  output logic o_clkout_oe,
  output logic o_port_override
);
  import scdt_pkg::*;

  scdt_state_t s_reg;
  scdt_state_t s_next;

  logic addr_ok;
  logic acc_div;
  logic acc_trim;
  logic [7:0] wbyte;
  logic [7:0] last_cnt;
  logic [7:0] half_cnt;
  logic [7:0] cnt_nx;
  logic div_wr;

  function automatic logic [7:0] period_last(input logic [3:0] sel);
    logic [8:0] f;
    f = 9'h001 << sel;
    return 8'(f - 9'h001);
  endfunction

  function automatic logic [7:0] period_half(input logic [3:0] sel);
    logic [8:0] f;
    f = 9'h001 << sel;
    return 8'(f >> 1);
  endfunction

  always_comb begin
    s_next = s_reg;
    addr_ok = i_ahb.hsel && i_ahb.hready && i_ahb.htrans[1];
    acc_div = (i_ahb.haddr == `SCDT_OFS_DIVCTL);
    acc_trim = (i_ahb.haddr == `SCDT_OFS_TRIM);
    wbyte = i_ahb.hwdata[7:0];
    last_cnt = period_last(s_reg.act_sel);
    half_cnt = period_half(s_reg.act_sel);
    cnt_nx = 8'h00;
    div_wr = 1'b0;

    // straps are caught on the first edge after reset release
    if (!s_reg.init) begin
      s_next.init = 1'b1;
      s_next.trim = i_trim_factory;
      s_next.sel = i_divide_by_eight_fuse ? `SCDT_SEL_DIV8 : `SCDT_SEL_RST;
      s_next.act_sel = s_next.sel;
    end

    // change enable window runs out on its own
    if (s_reg.ce) begin
      if (s_reg.ce_cnt == `SCDT_CE_WINDOW - 3'h1) begin
        s_next.ce = 1'b0;
        s_next.ce_cnt = 3'h0;
      end else begin
        s_next.ce_cnt = s_reg.ce_cnt + 3'h1;
      end
    end

    // data phase of a write
    if (s_reg.wr_pend && s_reg.init) begin
      if (s_reg.wr_div) begin
        if (wbyte == `SCDT_CE_WRITE) begin
          // a second set inside the window leaves the count alone
          if (!s_reg.ce) begin
            s_next.ce = 1'b1;
            s_next.ce_cnt = 3'h0;
          end
        end else if (!wbyte[`SCDT_CE_BIT] && s_reg.ce) begin
          s_next.sel = wbyte[`SCDT_SEL_MSB:0];
          s_next.ce = 1'b0;
          s_next.ce_cnt = 3'h0;
          div_wr = 1'b1;
        end
      end else begin
        s_next.trim = wbyte;
      end
    end

    // address phase
    s_next.wr_pend = 1'b0;
    s_next.wr_div = 1'b0;
    if (addr_ok) begin
      s_next.wr_pend = i_ahb.hwrite && (acc_div || acc_trim);
      s_next.wr_div = acc_div;
      s_next.rdata = 32'h0000_0000;
      if (!i_ahb.hwrite) begin
        if (acc_trim) begin
          s_next.rdata[7:0] = s_reg.trim;
        end else if (acc_div) begin
          // bits 6 to 4 stay zero
          s_next.rdata[`SCDT_CE_BIT] = s_reg.ce;
          s_next.rdata[`SCDT_SEL_MSB:0] = s_reg.sel;
        end
      end
    end

    // period counter on the undivided clock, hidden from software
    if (s_reg.cnt >= last_cnt) begin
      cnt_nx = 8'h00;
      s_next.tick = 1'b1;
      // new factor only at a period boundary so no short pulse appears
      if (s_reg.sel <= `SCDT_SEL_MAX) begin
        s_next.act_sel = s_reg.sel;
      end
    end else begin
      cnt_nx = s_reg.cnt + 8'h01;
      s_next.tick = 1'b0;
    end
    if (!s_reg.init) begin
      cnt_nx = 8'h00;
      s_next.tick = 1'b0;
    end
    s_next.cnt = cnt_nx;
    half_cnt = period_half(s_next.act_sel);
    // factor one has no low half; the level then just stays high
    s_next.clk_lvl = s_reg.init && ((half_cnt == 8'h00) || (cnt_nx < half_cnt));
    // fuse gates the pin at the output so pin and enable switch in the same cycle
    s_next.clkout = s_next.clk_lvl && s_reg.init;
    if (div_wr && (cnt_nx == 8'h00)) begin
      s_next.cnt = 8'h00;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  always_comb begin
    o_ahb.hrdata = s_reg.rdata;
    o_ahb.hreadyout = 1'b1;
    o_ahb.hresp = 1'b0;
    o_clk_dom.proc = s_reg.clk_lvl;
    o_clk_dom.flash = s_reg.clk_lvl;
    o_clk_dom.io = s_reg.clk_lvl;
    o_clk_dom.conv = s_reg.clk_lvl;
    o_sys_tick = s_reg.tick;
    o_oscillator_trim = s_reg.trim;
    o_trim_range_select = s_reg.trim[7];
    o_trim_fine = s_reg.trim[6:0];
    o_clkout_o = s_reg.clkout && i_clock_output_pin_fuse;
    o_clkout_oe = s_reg.init && i_clock_output_pin_fuse;
    o_port_override = s_reg.init && i_clock_output_pin_fuse;
  end
endmodule // scdt_top

// file: sim/scdt_monitor.sv
// port assertions for the clock divider and trim block
`timescale 1ns/1ps
module scdt_monitor (
  // clock, reset and fuses
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_clock_output_pin_fuse,
  input wire logic [7:0] i_trim_factory,
  // outputs watched
  input wire scdt_pkg::scdt_ahb_rsp_t o_ahb,
  input wire scdt_pkg::scdt_clk_dom_t o_clk_dom,
  input wire logic o_sys_tick,
  input wire logic [7:0] o_oscillator_trim,
  input wire logic o_trim_range_select,
  input wire logic [6:0] o_trim_fine,
  input wire logic o_clkout_o,
  input wire logic o_clkout_oe,
  input wire logic o_port_override
);
  import scdt_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  property p_dom; o_clk_dom == {4{o_clk_dom.io}}; endproperty
  a_dom: assert property (p_dom) else $error("domain clocks differ");
  property p_ovr; o_port_override == o_clkout_oe; endproperty
  a_ovr: assert property (p_ovr) else $error("override differs from enable");
  property p_off; !i_clock_output_pin_fuse [*2] |-> !o_clkout_oe && !o_clkout_o; endproperty
  a_off: assert property (p_off) else $error("pin driven without fuse");
  property p_rst; $rose(i_nrst) |-> !o_clkout_o && !o_clkout_oe; endproperty
  a_rst: assert property (p_rst) else $error("pin active in reset");
  property p_pin; o_clkout_oe |-> o_clkout_o == o_clk_dom.io; endproperty
  a_pin: assert property (p_pin) else $error("pin not divided clock");
  property p_split; {o_trim_range_select, o_trim_fine} == o_oscillator_trim; endproperty
  a_split: assert property (p_split) else $error("trim fields wrong");
  property p_ld; $rose(i_nrst) |-> ##[1:2] o_oscillator_trim == i_trim_factory; endproperty
  a_ld: assert property (p_ld) else $error("factory trim not loaded");
  property p_bus; o_ahb.hreadyout && !o_ahb.hresp; endproperty
  a_bus: assert property (p_bus) else $error("bus response not okay");
  c_tick: cover property (o_sys_tick);
  c_pin: cover property (o_clkout_oe && o_clkout_o);
  c_hi: cover property (o_trim_range_select);
endmodule // scdt_monitor

bind scdt_top scdt_monitor mon_u (.i_clk_sys, .i_nrst, .i_clock_output_pin_fuse,
  .i_trim_factory, .o_ahb, .o_clk_dom, .o_sys_tick, .o_oscillator_trim,
  .o_trim_range_select, .o_trim_fine, .o_clkout_o, .o_clkout_oe, .o_port_override);

// file: sim/tb_system_clock_divider_trim.sv
// self-checking bench for the clock divider and trim block
`timescale 1ns/1ps
`include "scdt_cfg.svh"
module tb_system_clock_divider_trim;
  import scdt_pkg::*;
  localparam logic [31:0] TR = `SCDT_OFS_TRIM;
  localparam logic [31:0] DV = `SCDT_OFS_DIVCTL;
  localparam logic [7:0] FT = 8'h5a;
  logic i_clk_sys, i_nrst, f8, fo, tick, oe, po, pin, rs;
  logic [7:0] trim;
  logic [6:0] fine;
  scdt_ahb_req_t q, bus;
  scdt_ahb_rsp_t o_ahb;
  scdt_clk_dom_t dom;
  int mismatches, tests_run;
  scdt_top dut_u (.i_clk_sys, .i_nrst, .i_divide_by_eight_fuse(f8),
    .i_clock_output_pin_fuse(fo), .i_trim_factory(FT), .i_ahb(bus), .o_ahb,
    .o_clk_dom(dom), .o_sys_tick(tick), .o_oscillator_trim(trim), .o_trim_range_select(rs),
    .o_trim_fine(fine), .o_clkout_o(pin), .o_clkout_oe(oe), .o_port_override(po));
  always_comb begin
    bus = q;
    bus.hready = o_ahb.hreadyout;
  end
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  task automatic conclude;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic hw;
    int k;
    k = 0;
    do @(posedge i_clk_sys); while (o_ahb.hreadyout !== 1'b1 && ++k < 50);
    if (o_ahb.hreadyout !== 1'b1) begin
      mismatches++;
      conclude;
    end
  endtask
  task automatic xf(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    q.haddr <= a;
    q.hwrite <= w;
    q.htrans <= 2'h2;
    hw;
    q.htrans <= 2'h0;
    q.hwdata <= d;
    hw;
    r = o_ahb.hrdata;
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    xf(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [31:0] a, e);
    logic [31:0] r;
    xf(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic wt(output int c);
    c = 0;
    do @(negedge i_clk_sys); while (tick !== 1'b1 && ++c < 600);
    if (tick !== 1'b1) begin
      mismatches++;
      conclude;
    end
  endtask
  // first period after a change may be mixed, so measure the third
  task automatic per(input int e);
    int c;
    wt(c);
    wt(c);
    wt(c);
    chk(32'(c + 1), 32'(e));
  endtask
  task automatic t_rst(input logic f);
    i_nrst <= 1'b0;
    f8 <= f;
    repeat (12) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    rd(TR, 32'(FT));
    rd(DV, f ? 32'h3 : 32'h0);
    chk(32'(oe & po), 32'h1);
  endtask
  task automatic t_trim;
    wr(TR, 32'h70);
    rd(TR, 32'h70);
    wr(TR, 32'h7f);
    rd(TR, 32'h7f);
    chk(32'(rs), 32'h0);
    chk(32'(fine), 32'h7f);
    wr(TR, 32'h80);
    rd(TR, 32'h80);
    chk(32'(rs), 32'h1);
  endtask
  task automatic t_prot;
    wr(DV, 32'h05);
    wr(DV, 32'h81);
    wr(32'h8, 32'hff);
    rd(32'h8, 32'h0);
    rd(DV, 32'h3);
    per(8);
  endtask
  task automatic t_codes;
    for (int n = 0; n < 10; n++) begin
      wr(DV, 32'h80);
      wr(DV, 32'(n));
      rd(DV, 32'(n));
      per(n > 8 ? 256 : 1 << n);
    end
  endtask
  task automatic t_win;
    wr(DV, 32'h80);
    repeat (5) @(posedge i_clk_sys);
    wr(DV, 32'h2);
    rd(DV, 32'h9);
    wr(DV, 32'h80);
    wr(DV, 32'h80);
    rd(DV, 32'h89);
    wr(DV, 32'h1);
    rd(DV, 32'h9);
  endtask
  task automatic t_pin;
    fo <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    chk(32'({oe, pin, po}), 32'h0);
    fo <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    chk(32'(oe & po), 32'h1);
    chk(32'(pin), 32'(dom.io));
  endtask
  initial begin
    mismatches = 0;
    tests_run = 0;
    q = '0;
    q.hsel = 1'b1;
    q.hsize = 3'h2;
    i_nrst = 1'b0;
    f8 = 1'b1;
    fo = 1'b1;
    t_rst(1'b1);
    t_trim;
    t_prot;
    t_codes;
    t_win;
    t_pin;
    t_rst(1'b0);
    conclude;
  end
endmodule // tb_system_clock_divider_trim
